// file: core/iwdt_pkg.sv
// Constants shared by the independent watchdog: register map, command keys,
// field positions, reset values and widths.
// Assumes a 32-bit APB with byte addresses, one register per aligned word.
package iwdt_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned IWDT_ADDR_W  = 12;
    localparam int unsigned IWDT_DATA_W  = 32;
    localparam int unsigned IWDT_KEY_W   = 16;
    localparam int unsigned IWDT_CNT_W   = 12;
    localparam int unsigned IWDT_SEL_W   = 3;
    localparam int unsigned IWDT_PRESC_W = 8;
    localparam int unsigned IWDT_SYNC_W  = 3;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] IWDT_OFS_COMMAND = 12'h000;
    localparam logic [11:0] IWDT_OFS_DIVIDER = 12'h004;
    localparam logic [11:0] IWDT_OFS_RELOAD  = 12'h008;
    localparam logic [11:0] IWDT_OFS_STATUS  = 12'h00C;
    localparam logic [11:0] IWDT_OFS_CONFIG  = 12'h010;
    localparam logic [11:0] IWDT_OFS_COUNT   = 12'h014;

    // ------------------------------------------------------------------
    // Command keys
    // ------------------------------------------------------------------
    localparam logic [15:0] IWDT_KEY_UNLOCK = 16'h5555;
    localparam logic [15:0] IWDT_KEY_START  = 16'hCCCC;
    localparam logic [15:0] IWDT_KEY_RELOAD = 16'hAAAA;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned IWDT_STAT_DIV_BUSY_BIT    = 0;
    localparam int unsigned IWDT_STAT_RELOAD_BUSY_BIT = 1;
    localparam int unsigned IWDT_STAT_RUNNING_BIT     = 2;
    localparam int unsigned IWDT_CFG_FREEZE_BIT       = 0;
    localparam int unsigned IWDT_SYNC_OSC_BIT         = 0;
    localparam int unsigned IWDT_SYNC_HALT_BIT        = 1;
    localparam int unsigned IWDT_SYNC_STRAP_BIT       = 2;

    // ------------------------------------------------------------------
    // Reset values and divider coding
    // ------------------------------------------------------------------
    localparam logic [11:0] IWDT_RELOAD_RST = 12'hFFF;
    localparam logic [11:0] IWDT_COUNT_RST  = 12'hFFF;
    localparam logic [2:0]  IWDT_SEL_RST    = 3'h0;
    localparam logic [2:0]  IWDT_SEL_MAX    = 3'h6;
    localparam logic [7:0]  IWDT_DIV_BASE   = 8'h04;
    localparam logic [7:0]  IWDT_DIV_TOP    = 8'hFF;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    // Edge after reset release that reads the strap past both sync flops
    localparam logic [1:0]  IWDT_STRAP_SETTLE = 2'h3;

    typedef enum logic {
        IWDT_BUS_IDLE,
        IWDT_BUS_ANSWER
    } iwdt_bus_e;

endpackage

// file: core/iwdt_sync.sv
// Two-flop synchronisers with a rising-edge pulse per bit.
// Assumes asynchronous inputs from pins or from the slow oscillator; the
// edge pulse is built only from the second and third stages.
`timescale 1ns/100ps

module iwdt_sync #(
    parameter int unsigned WIDTH = 3
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Asynchronous inputs
    input  wire logic [WIDTH-1:0] async_in,
    // Synchronised outputs
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] rise_out
);

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            logic stage1_reg;
            logic stage2_reg;
            logic stage3_reg;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1_reg <= 1'b0;
                    stage2_reg <= 1'b0;
                    stage3_reg <= 1'b0;
                end else begin
                    stage1_reg <= async_in[gi];
                    stage2_reg <= stage1_reg;
                    stage3_reg <= stage2_reg;
                end
            end

            assign level_out[gi] = stage2_reg;
            assign rise_out[gi]  = stage2_reg & ~stage3_reg;
        end
    endgenerate

endmodule

// file: core/iwdt_independent_watchdog.sv
// Independent watchdog: 8-stage prescaler and 12-bit down counter paced by
// the slow internal oscillator, with key-based command register over APB.
// Assumes pclk is well above twice the slow oscillator rate; the oscillator
// is sampled as a pin and each of its rising edges is one slow tick.
//
// Functional notes
// RULE1: 12-bit down counter decrements on prescaled ticks
// RULE2: Counter at zero raises system reset request
// RULE3: Start key enables the watchdog counting down
// RULE4: Reload key loads counter from reload value
// RULE5: Software reloads before zero to avoid reset
// RULE6: Divider codes 4..128 doubling, 110/111 give 256
// RULE7: Divider and reload writable only after unlock key
// RULE8: Any other command value restores write protection
// RULE9: Busy flags set while configuration update pending
// RULE10: Option strap starts watchdog at power-on
// RULE11: Debug freeze bit stops counter during halt
// RULE12: Counter paced by dedicated 40 kHz oscillator
// RULE13: Software waits three slow ticks before sleep
// RULE14: Divider write sets busy, reads invalid meanwhile
// RULE15: Reload write sets busy, reads invalid meanwhile
// RULE16: Reload value resets to 0xFFF
// RULE17: Unknown command values only restore protection
// RULE18: Bus updates pass to slow tick, flags clear
`timescale 1ns/100ps

module iwdt_independent_watchdog
(
    // Clock and reset
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    // APB slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [iwdt_pkg::IWDT_ADDR_W-1:0] paddr,
    input  wire logic [iwdt_pkg::IWDT_DATA_W-1:0] pwdata,
    output logic      [iwdt_pkg::IWDT_DATA_W-1:0] prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // Slow oscillator and system pins
    input  wire logic                            slow_internal_osc,
    input  wire logic                            core_halted,
    input  wire logic                            hw_watchdog_strap,
    // Watchdog outputs
    output logic                                 watchdog_reset_req,
    output logic                                 watchdog_running
);

    import iwdt_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [IWDT_SYNC_W-1:0] sync_level;
    logic [IWDT_SYNC_W-1:0] sync_rise;
    logic                   osc_tick;
    logic                   halted_s;
    logic                   strap_s;

    iwdt_sync #(
        .WIDTH     (IWDT_SYNC_W)
    ) u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .async_in  ({hw_watchdog_strap, core_halted, slow_internal_osc}),
        .level_out (sync_level),
        .rise_out  (sync_rise)
    );

    assign osc_tick = sync_rise[IWDT_SYNC_OSC_BIT];   // RULE12
    assign halted_s = sync_level[IWDT_SYNC_HALT_BIT];
    assign strap_s  = sync_level[IWDT_SYNC_STRAP_BIT];

    // ------------------------------------------------------------------
    // APB slave state
    // ------------------------------------------------------------------
    iwdt_bus_e               bus_state_reg;
    iwdt_bus_e               bus_state_next;
    logic [IWDT_DATA_W-1:0]  prdata_reg;
    logic [IWDT_DATA_W-1:0]  prdata_next;
    logic                    pready_reg;
    logic                    pready_next;
    logic                    pslverr_reg;
    logic                    pslverr_next;

    // ------------------------------------------------------------------
    // Watchdog state
    // ------------------------------------------------------------------
    logic                    running_reg;
    logic                    running_next;
    logic                    unlock_reg;
    logic                    unlock_next;
    logic                    start_pend_reg;
    logic                    start_pend_next;
    logic                    reload_pend_reg;
    logic                    reload_pend_next;
    logic [IWDT_SEL_W-1:0]   divider_select_reg;
    logic [IWDT_SEL_W-1:0]   divider_select_next;
    logic [IWDT_SEL_W-1:0]   div_active_reg;
    logic [IWDT_SEL_W-1:0]   div_active_next;
    logic [IWDT_CNT_W-1:0]   reload_value_reg;
    logic [IWDT_CNT_W-1:0]   reload_value_next;
    logic [IWDT_CNT_W-1:0]   reload_active_reg;
    logic [IWDT_CNT_W-1:0]   reload_active_next;
    logic                    divider_update_busy_reg;
    logic                    divider_update_busy_next;
    logic                    reload_update_busy_reg;
    logic                    reload_update_busy_next;
    logic [IWDT_CNT_W-1:0]   count_reg;
    logic [IWDT_CNT_W-1:0]   count_next;
    logic [IWDT_PRESC_W-1:0] presc_reg;
    logic [IWDT_PRESC_W-1:0] presc_next;
    logic                    reset_req_reg;
    logic                    reset_req_next;
    logic                    debug_freeze_reg;
    logic                    debug_freeze_next;
    logic [1:0]              boot_cnt_reg;
    logic [1:0]              boot_cnt_next;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic                    access;
    logic                    wr_fire;
    logic                    hit_command;
    logic                    hit_divider;
    logic                    hit_reload;
    logic                    hit_status;
    logic                    hit_config;
    logic                    hit_count;
    logic                    addr_ok;
    logic [IWDT_KEY_W-1:0]   wr_key;
    logic                    cmd_write;
    logic                    cmd_unlock;
    logic                    cmd_start;
    logic                    cmd_reload;
    logic                    div_write;
    logic                    reload_write;
    logic                    frozen;
    logic [IWDT_PRESC_W-1:0] div_mask;
    logic [IWDT_CNT_W-1:0]   reload_source;

    assign access      = psel & penable;
    // A write takes effect only at the edge that completes the transfer
    assign wr_fire     = access & pwrite & (bus_state_reg == IWDT_BUS_ANSWER);
    assign hit_command = (paddr == IWDT_OFS_COMMAND);
    assign hit_divider = (paddr == IWDT_OFS_DIVIDER);
    assign hit_reload  = (paddr == IWDT_OFS_RELOAD);
    assign hit_status  = (paddr == IWDT_OFS_STATUS);
    assign hit_config  = (paddr == IWDT_OFS_CONFIG);
    assign hit_count   = (paddr == IWDT_OFS_COUNT);
    assign addr_ok     = hit_command | hit_divider | hit_reload |
                         hit_status | hit_config | hit_count;
    assign wr_key      = pwdata[IWDT_KEY_W-1:0];

    assign cmd_write    = wr_fire & hit_command;
    assign cmd_unlock   = cmd_write & (wr_key == IWDT_KEY_UNLOCK);   // RULE7
    assign cmd_start    = cmd_write & (wr_key == IWDT_KEY_START);    // RULE3
    assign cmd_reload   = cmd_write & (wr_key == IWDT_KEY_RELOAD);   // RULE4
    // Locked writes are dropped silently, the bus still answers OKAY
    assign div_write    = wr_fire & hit_divider & unlock_reg;        // RULE7
    assign reload_write = wr_fire & hit_reload & unlock_reg;         // RULE7

    assign frozen = debug_freeze_reg & halted_s;                     // RULE11

    // Reload takes the value still in transit if one is pending
    assign reload_source = reload_update_busy_reg ? reload_value_reg : reload_active_reg;

    // ------------------------------------------------------------------
    // Divider mask
    // ------------------------------------------------------------------
    assign div_mask = (div_active_reg >= IWDT_SEL_MAX) ? IWDT_DIV_TOP :
                      8'((IWDT_DIV_BASE << div_active_reg) - 8'h01);   // RULE6

    // ------------------------------------------------------------------
    // APB next state
    // ------------------------------------------------------------------
    always_comb begin
        bus_state_next = bus_state_reg;
        prdata_next    = '0;
        pready_next    = 1'b0;
        pslverr_next   = 1'b0;
        case (bus_state_reg)
            IWDT_BUS_IDLE: begin
                if (access) begin
                    // One wait state: read data and error are prepared here
                    bus_state_next = IWDT_BUS_ANSWER;
                    pready_next    = 1'b1;
                    pslverr_next   = ~addr_ok;
                    if (!pwrite) begin
                        if (hit_divider && !divider_update_busy_reg) begin
                            prdata_next[IWDT_SEL_W-1:0] = divider_select_reg;
                        end else if (hit_reload && !reload_update_busy_reg) begin
                            prdata_next[IWDT_CNT_W-1:0] = reload_value_reg;
                        end else if (hit_status) begin
                            prdata_next[IWDT_STAT_DIV_BUSY_BIT]    = divider_update_busy_reg;
                            prdata_next[IWDT_STAT_RELOAD_BUSY_BIT] = reload_update_busy_reg;
                            prdata_next[IWDT_STAT_RUNNING_BIT]     = running_reg;
                        end else if (hit_config) begin
                            prdata_next[IWDT_CFG_FREEZE_BIT] = debug_freeze_reg;
                        end else if (hit_count) begin
                            prdata_next[IWDT_CNT_W-1:0] = count_reg;
                        end
                    end
                end
            end
            default: begin
                bus_state_next = IWDT_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state_reg <= IWDT_BUS_IDLE;
            prdata_reg    <= '0;
            pready_reg    <= 1'b0;
            pslverr_reg   <= 1'b0;
        end else begin
            bus_state_reg <= bus_state_next;
            prdata_reg    <= prdata_next;
            pready_reg    <= pready_next;
            pslverr_reg   <= pslverr_next;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog next state
    // ------------------------------------------------------------------
    always_comb begin
        running_next             = running_reg;
        unlock_next              = unlock_reg;
        start_pend_next          = start_pend_reg;
        reload_pend_next         = reload_pend_reg;
        divider_select_next      = divider_select_reg;
        div_active_next          = div_active_reg;
        reload_value_next        = reload_value_reg;
        reload_active_next       = reload_active_reg;
        divider_update_busy_next = divider_update_busy_reg;
        reload_update_busy_next  = reload_update_busy_reg;
        count_next               = count_reg;
        presc_next               = presc_reg;
        reset_req_next           = reset_req_reg;
        debug_freeze_next        = debug_freeze_reg;
        boot_cnt_next            = boot_cnt_reg;

        // Strap is read once the synchroniser holds its settled value
        if (boot_cnt_reg != IWDT_STRAP_SETTLE) begin
            boot_cnt_next = 2'(boot_cnt_reg + 2'h1);
            if (2'(boot_cnt_reg + 2'h1) == IWDT_STRAP_SETTLE && strap_s) begin
                running_next = 1'b1;                                  // RULE10
            end
        end

        // Slow-domain transfers complete on a tick; new requests win
        if (osc_tick) begin
            if (start_pend_reg) begin
                running_next = 1'b1;                                  // RULE3
            end
            if (divider_update_busy_reg) begin
                div_active_next = divider_select_reg;                 // RULE18
            end
            if (reload_update_busy_reg) begin
                reload_active_next = reload_value_reg;                // RULE18
            end
            start_pend_next          = 1'b0;
            reload_pend_next         = 1'b0;
            divider_update_busy_next = 1'b0;                          // RULE18
            reload_update_busy_next  = 1'b0;                          // RULE18

            if (reload_pend_reg) begin
                count_next = reload_source;                           // RULE4
                presc_next = '0;
            end else if (running_reg && !frozen) begin                // RULE11
                if (count_reg == '0) begin
                    reset_req_next = 1'b1;                            // RULE2
                end else begin
                    presc_next = 8'(presc_reg + 8'h01);
                    if ((presc_reg & div_mask) == div_mask) begin
                        presc_next = '0;
                        count_next = 12'(count_reg - 12'h001);        // RULE1
                    end
                end
            end
        end

        // Command register: every write relocks unless it is the unlock key
        if (cmd_write) begin
            unlock_next = cmd_unlock;                                 // RULE8 RULE17
        end
        if (cmd_start) begin
            start_pend_next = 1'b1;                                   // RULE3
        end
        if (cmd_reload) begin
            reload_pend_next = 1'b1;                                  // RULE4
        end
        if (div_write) begin
            divider_select_next      = pwdata[IWDT_SEL_W-1:0];
            divider_update_busy_next = 1'b1;                          // RULE9 RULE14
        end
        if (reload_write) begin
            reload_value_next       = pwdata[IWDT_CNT_W-1:0];
            reload_update_busy_next = 1'b1;                           // RULE9 RULE15
        end
        if (wr_fire && hit_config) begin
            debug_freeze_next = pwdata[IWDT_CFG_FREEZE_BIT];          // RULE11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_reg             <= 1'b0;
            unlock_reg              <= 1'b0;
            start_pend_reg          <= 1'b0;
            reload_pend_reg         <= 1'b0;
            divider_select_reg      <= IWDT_SEL_RST;
            div_active_reg          <= IWDT_SEL_RST;
            reload_value_reg        <= IWDT_RELOAD_RST;               // RULE16
            reload_active_reg       <= IWDT_RELOAD_RST;               // RULE16
            divider_update_busy_reg <= 1'b0;
            reload_update_busy_reg  <= 1'b0;
            count_reg               <= IWDT_COUNT_RST;
            presc_reg               <= '0;
            reset_req_reg           <= 1'b0;
            debug_freeze_reg        <= 1'b0;
            boot_cnt_reg            <= 2'h0;
        end else begin
            running_reg             <= running_next;
            unlock_reg              <= unlock_next;
            start_pend_reg          <= start_pend_next;
            reload_pend_reg         <= reload_pend_next;
            divider_select_reg      <= divider_select_next;
            div_active_reg          <= div_active_next;
            reload_value_reg        <= reload_value_next;
            reload_active_reg       <= reload_active_next;
            divider_update_busy_reg <= divider_update_busy_next;
            reload_update_busy_reg  <= reload_update_busy_next;
            count_reg               <= count_next;
            presc_reg               <= presc_next;
            reset_req_reg           <= reset_req_next;
            debug_freeze_reg        <= debug_freeze_next;
            boot_cnt_reg            <= boot_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Reset request stays up until the system reset clears this block
    assign watchdog_reset_req = reset_req_reg;
    assign watchdog_running   = running_reg;
    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;

endmodule

// file: sim/iwdt_checker.sv
// Port checker for the watchdog: bus answer timing and sticky outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module iwdt_checker
    import iwdt_pkg::*;
(
    // Bus side
    input wire logic                             pclk,
    input wire logic                             presetn,
    input wire logic                             psel,
    input wire logic                             penable,
    input wire logic                             pwrite,
    input wire logic [iwdt_pkg::IWDT_ADDR_W-1:0] paddr,
    input wire logic [iwdt_pkg::IWDT_DATA_W-1:0] prdata,
    input wire logic                             pready,
    input wire logic                             pslverr,
    // Watchdog outputs
    input wire logic                             watchdog_reset_req,
    input wire logic                             watchdog_running
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("answer not one wait state late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    idle_bus_a: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("bus outputs active without ready");
    cmd_read_a: assert property (pready && !pwrite && paddr == IWDT_OFS_COMMAND |->
        prdata == 32'h0 && !pslverr) else $error("command read not zero");
    unmapped_err_a: assert property (pready && paddr > IWDT_OFS_COUNT |-> pslverr)
        else $error("unmapped access without error");
    req_sticky_a: assert property (watchdog_reset_req |=> watchdog_reset_req)
        else $error("reset request dropped");
    req_running_a: assert property (watchdog_reset_req |-> watchdog_running)
        else $error("reset request while stopped");
    run_sticky_a: assert property (watchdog_running |=> watchdog_running)
        else $error("watchdog stopped without reset");
endmodule

bind iwdt_independent_watchdog iwdt_checker u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .watchdog_reset_req, .watchdog_running);

// file: sim/iwdt_independent_watchdog_tb.sv
// Self-checking bench for the watchdog, driving APB and the slow oscillator.
// Assumes the checker is compiled alongside; oscillator period is 40 pclk.
`timescale 1ns/100ps
module iwdt_independent_watchdog_tb;
    import iwdt_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        slow_internal_osc = 0, core_halted = 0, hw_watchdog_strap = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, watchdog_reset_req, watchdog_running;
    logic [33:0] exp_q[$], ev;
    int          miscompares = 0, num_checks = 0, cyc = 0, osc_cnt = 0, d;
    iwdt_independent_watchdog DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .slow_internal_osc, .core_halted, .hw_watchdog_strap,
        .watchdog_reset_req, .watchdog_running);
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        osc_cnt <= (osc_cnt + 1) % 40;
        slow_internal_osc <= (osc_cnt < 20);
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            miscompares++;
            stop_test();
        end
    end
    // ------------------------------------------------------------------
    // Compare and bus tasks
    // ------------------------------------------------------------------
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    always @(posedge pclk) if (pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
        ev = exp_q.pop_front();
        chk("pslverr", 32'(ev[32]), 32'(pslverr));
        if (ev[33])
            chk("prdata", ev[31:0], prdata);
    end
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] w, logic [33:0] e);
        if (!wr)
            exp_q.push_back(e);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] w);
        apb(1'b1, a, w, 34'h0);
    endtask
    task automatic rdx(logic [11:0] a, logic [31:0] e);
        apb(1'b0, a, 32'h0, {2'b10, e});
    endtask
    task automatic ticks(int k);
        repeat (k) @(posedge slow_internal_osc);
        repeat (6) @(posedge pclk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(45236));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdx(IWDT_OFS_RELOAD, 32'hFFF);
        rdx(IWDT_OFS_DIVIDER, 32'h0);
        rdx(IWDT_OFS_STATUS, 32'h0);
        apb(1'b0, 12'h018 + 12'($urandom % 16) * 12'h4, 32'h0, {2'b01, 32'h0});
        rdx(IWDT_OFS_COMMAND, 32'h0);
        $display("test reset values done");
        wr(IWDT_OFS_RELOAD, $urandom);
        wr(IWDT_OFS_COMMAND, 32'h5555);
        wr(IWDT_OFS_COMMAND, 32'h1234);
        wr(IWDT_OFS_RELOAD, 32'h7);
        ticks(2);
        rdx(IWDT_OFS_RELOAD, 32'hFFF);
        wr(IWDT_OFS_COMMAND, 32'h5555);
        wr(IWDT_OFS_RELOAD, 32'h2);
        wr(IWDT_OFS_DIVIDER, 32'h5);
        rdx(IWDT_OFS_STATUS, 32'h3);
        rdx(IWDT_OFS_RELOAD, 32'h0);
        ticks(1);
        rdx(IWDT_OFS_DIVIDER, 32'h5);
        rdx(IWDT_OFS_STATUS, 32'h0);
        wr(IWDT_OFS_COMMAND, 32'hCCCC);
        ticks(2);
        rdx(IWDT_OFS_STATUS, 32'h4);
        $display("test protection and start done");
        for (int s = 0; s < 8; s++) begin
            d = (s > 5) ? 256 : 4 << s;
            wr(IWDT_OFS_COMMAND, 32'h5555);
            wr(IWDT_OFS_DIVIDER, 32'(s));
            wr(IWDT_OFS_RELOAD, 32'hFFF);
            ticks(2);
            wr(IWDT_OFS_COMMAND, 32'hAAAA);
            ticks(1 + d + d / 2);
            rdx(IWDT_OFS_COUNT, 32'hFFE);
        end
        $display("test divider codes done");
        wr(IWDT_OFS_COMMAND, 32'h5555);
        wr(IWDT_OFS_DIVIDER, 32'h0);
        wr(IWDT_OFS_RELOAD, 32'h2);
        wr(IWDT_OFS_CONFIG, 32'h1);
        core_halted <= 1'b1;
        ticks(2);
        wr(IWDT_OFS_COMMAND, 32'hAAAA);
        ticks(20);
        rdx(IWDT_OFS_COUNT, 32'h2);
        core_halted <= 1'b0;
        repeat (3) begin
            wr(IWDT_OFS_COMMAND, 32'hAAAA);
            ticks(6);
        end
        chk("reset_req", 32'h0, 32'(watchdog_reset_req));
        ticks(2);
        chk("reset_req", 32'h0, 32'(watchdog_reset_req));
        ticks(4);
        chk("reset_req", 32'h1, 32'(watchdog_reset_req));
        $display("test timeout done");
        presetn <= 1'b0;
        hw_watchdog_strap <= 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("running", 32'h1, 32'(watchdog_running));
        rdx(IWDT_OFS_STATUS, 32'h4);
        $display("test strap start done");
        stop_test();
    end
endmodule
